//--- rtl/csl_strap_latch.sv
// Strap latch for the external MII port and management configuration.
// Assumes straps and the external reset pin are synchronous to core_clk.

`timescale 1ns/1ps
`default_nettype none

module csl_strap_latch
    import csl_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // Strap pins and external reset pin
    input  wire logic                  ext_port_fc_enable_strap,
    input  wire logic                  ext_port_manual_fc_strap,
    input  wire logic [1:0]            mgmt_mode_strap,
    input  wire logic                  mii_role_strap,
    input  wire logic                  phy_addr_base_strap,
    input  wire logic                  ext_reset_n,
    // EEPROM loader override
    input  wire logic                  eep_load_valid,
    input  wire csl_eep_t              eep_load,
    // Register port
    input  wire logic [CSL_ADDR_W-1:0] reg_addr,
    input  wire logic [CSL_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [CSL_DATA_W-1:0]      reg_rdata,
    // Latched configuration
    output logic                       ext_tx_flowctl_enable,
    output logic                       ext_rx_flowctl_enable,
    output logic                       ext_manual_flowctl_select,
    output logic                       mgmt_unmanaged,
    output logic                       extended_mgmt_serial,
    output logic                       mgmt_i2c_slave,
    output logic                       mgmt_spi_slave,
    output logic                       mii_phy_role,
    output logic [4:0]                 virt_phy_addr,
    output logic [4:0]                 port1_phy_addr,
    output logic [4:0]                 port2_phy_addr,
    output logic                       straps_valid
);

    // ------------------------------------------------------------
    // Capture sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CSL_ST_PENDING = 3'b001,
        CSL_ST_HELD    = 3'b010,
        CSL_ST_EXTRST  = 3'b100
    } csl_state_t;

    csl_state_t state_reg;
    csl_state_t state_next;

    // Power-on reset parks the sequencer in PENDING, so the first edge after release
    // with the external pin high takes the straps; the pins are never read under reset.
    wire logic capture_now = (state_reg == CSL_ST_PENDING) && ext_reset_n;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CSL_ST_PENDING: begin
                if (ext_reset_n) begin
                    state_next = CSL_ST_HELD;
                end
            end
            CSL_ST_HELD: begin
                if (!ext_reset_n) begin
                    state_next = CSL_ST_EXTRST;
                end
            end
            CSL_ST_EXTRST: begin
                if (ext_reset_n) begin
                    state_next = CSL_ST_PENDING;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= CSL_ST_PENDING;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Strap snapshot
    // ------------------------------------------------------------
    csl_strap_t strap_live;
    csl_strap_t strap_q;

    assign strap_live = '{
        fc_en:     ext_port_fc_enable_strap,
        manual_fc: ext_port_manual_fc_strap,
        mgmt_mode: mgmt_mode_strap,
        mii_role:  mii_role_strap,
        addr_base: phy_addr_base_strap
    };

    csl_strap_capture u_capture (
        .core_clk (core_clk),
        .rstn     (rstn),
        .capture  (capture_now),
        .strap_in (strap_live),
        .strap_q  (strap_q)
    );

    // ------------------------------------------------------------
    // Defaults derived from the live straps
    // ------------------------------------------------------------
    wire logic       is_mac_role = (strap_live.mii_role == CSL_ROLE_MAC);
    // Without a virtual PHY there is nothing to negotiate, so MAC role forces manual.
    wire logic       dflt_manual = is_mac_role ? CSL_MAC_MANUAL_SEL
                                               : strap_live.manual_fc;
    wire logic [4:0] dflt_virt   = csl_phy_addr(strap_live.addr_base, CSL_VIRT_OFS);
    wire logic [4:0] dflt_p1     = csl_phy_addr(strap_live.addr_base, CSL_P1_OFS);
    wire logic [4:0] dflt_p2     = csl_phy_addr(strap_live.addr_base, CSL_P2_OFS);

    csl_cfg_t cfg_dflt;

    assign cfg_dflt = '{
        tx_fc:      strap_live.fc_en,
        rx_fc:      strap_live.fc_en,
        manual_sel: dflt_manual,
        virt_addr:  dflt_virt,
        p1_addr:    dflt_p1,
        p2_addr:    dflt_p2
    };

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire logic hit_status  = (reg_addr == CSL_OFF_STATUS);
    wire logic hit_flow    = (reg_addr == CSL_OFF_FLOW);
    wire logic hit_mgmt    = (reg_addr == CSL_OFF_MGMT);
    wire logic hit_phyaddr = (reg_addr == CSL_OFF_PHYADDR);
    wire logic hit_count   = (reg_addr == CSL_OFF_COUNT);
    wire logic wr_flow     = reg_wr && hit_flow;
    wire logic wr_phyaddr  = reg_wr && hit_phyaddr;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    csl_cfg_t   cfg_reg;
    csl_cfg_t   cfg_next;
    logic [1:0] mode_reg;
    logic       role_reg;
    logic       valid_reg;
    logic [CSL_CNT_W-1:0] count_reg;

    // Order of precedence: capture, then the EEPROM loader, then software.
    // Only a capture, an override or a write moves a value; otherwise it holds.
    always_comb begin
        cfg_next = cfg_reg;
        if (capture_now) begin
            cfg_next = cfg_dflt;
        end else begin
            if (wr_flow) begin
                cfg_next.tx_fc      = reg_wdata[CSL_FLOW_TX_BIT];
                cfg_next.rx_fc      = reg_wdata[CSL_FLOW_RX_BIT];
                cfg_next.manual_sel = reg_wdata[CSL_FLOW_MAN_BIT];
            end
            if (wr_phyaddr) begin
                cfg_next.virt_addr = reg_wdata[CSL_PA_VIRT_LSB +: CSL_PA_W];
                cfg_next.p1_addr   = reg_wdata[CSL_PA_P1_LSB +: CSL_PA_W];
                cfg_next.p2_addr   = reg_wdata[CSL_PA_P2_LSB +: CSL_PA_W];
            end
            if (eep_load_valid && eep_load.flow_valid) begin
                cfg_next.tx_fc      = eep_load.cfg.tx_fc;
                cfg_next.rx_fc      = eep_load.cfg.rx_fc;
                cfg_next.manual_sel = eep_load.cfg.manual_sel;
            end
            if (eep_load_valid && eep_load.addr_valid) begin
                cfg_next.virt_addr = eep_load.cfg.virt_addr;
                cfg_next.p1_addr   = eep_load.cfg.p1_addr;
                cfg_next.p2_addr   = eep_load.cfg.p2_addr;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= CSL_CFG_RST;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mode_reg  <= CSL_MGMT_UNMANAGED;
            role_reg  <= CSL_ROLE_MAC;
            valid_reg <= 1'b0;
            count_reg <= '0;
        end else if (capture_now) begin
            mode_reg  <= strap_live.mgmt_mode;
            role_reg  <= strap_live.mii_role;
            valid_reg <= 1'b1;
            count_reg <= count_reg + 8'h01;
        end else if (state_reg == CSL_ST_EXTRST) begin
            valid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------
    wire logic [3:0] mode_onehot = 4'h1 << mode_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ext_tx_flowctl_enable     <= 1'b0;
            ext_rx_flowctl_enable     <= 1'b0;
            ext_manual_flowctl_select <= 1'b0;
            mgmt_unmanaged            <= 1'b1;
            extended_mgmt_serial      <= 1'b0;
            mgmt_i2c_slave            <= 1'b0;
            mgmt_spi_slave            <= 1'b0;
            mii_phy_role              <= CSL_ROLE_MAC;
            virt_phy_addr             <= 5'h00;
            port1_phy_addr            <= 5'h00;
            port2_phy_addr            <= 5'h00;
            straps_valid              <= 1'b0;
        end else begin
            ext_tx_flowctl_enable     <= cfg_reg.tx_fc;
            ext_rx_flowctl_enable     <= cfg_reg.rx_fc;
            ext_manual_flowctl_select <= cfg_reg.manual_sel;
            mgmt_unmanaged            <= mode_onehot[CSL_MGMT_UNMANAGED];
            extended_mgmt_serial      <= mode_onehot[CSL_MGMT_EXT_SERIAL];
            mgmt_i2c_slave            <= mode_onehot[CSL_MGMT_I2C];
            mgmt_spi_slave            <= mode_onehot[CSL_MGMT_SPI];
            mii_phy_role              <= role_reg;
            virt_phy_addr             <= cfg_reg.virt_addr;
            port1_phy_addr            <= cfg_reg.p1_addr;
            port2_phy_addr            <= cfg_reg.p2_addr;
            straps_valid              <= valid_reg;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped offsets read as zero; data stand for exactly one cycle after the strobe.
    wire logic [CSL_DATA_W-1:0] rd_status  = {26'h0, strap_q};
    wire logic [CSL_DATA_W-1:0] rd_flow    = {29'h0, cfg_reg.manual_sel,
                                              cfg_reg.rx_fc, cfg_reg.tx_fc};
    wire logic [CSL_DATA_W-1:0] rd_mgmt    = {21'h0, state_reg, 5'h00, role_reg, mode_reg};
    wire logic [CSL_DATA_W-1:0] rd_phyaddr = {11'h0, cfg_reg.p2_addr, 3'h0,
                                              cfg_reg.p1_addr, 3'h0, cfg_reg.virt_addr};
    wire logic [CSL_DATA_W-1:0] rd_count   = {24'h0, count_reg};

    wire logic [CSL_DATA_W-1:0] rd_mux =
        ({CSL_DATA_W{hit_status}}  & rd_status)  |
        ({CSL_DATA_W{hit_flow}}    & rd_flow)    |
        ({CSL_DATA_W{hit_mgmt}}    & rd_mgmt)    |
        ({CSL_DATA_W{hit_phyaddr}} & rd_phyaddr) |
        ({CSL_DATA_W{hit_count}}   & rd_count);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

endmodule : csl_strap_latch

`default_nettype wire

//--- rtl/csl_pkg.sv
// Package of the strap latch: register map, field layout, encodings and carriers.
// Assumes one core clock domain; every strap pin is already synchronous to it.

package csl_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int unsigned CSL_ADDR_W = 8;
    localparam int unsigned CSL_DATA_W = 32;

    localparam logic [7:0] CSL_OFF_STATUS  = 8'h00;
    localparam logic [7:0] CSL_OFF_FLOW    = 8'h04;
    localparam logic [7:0] CSL_OFF_MGMT    = 8'h08;
    localparam logic [7:0] CSL_OFF_PHYADDR = 8'h0c;
    localparam logic [7:0] CSL_OFF_COUNT   = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CSL_FLOW_TX_BIT   = 0;
    localparam int unsigned CSL_FLOW_RX_BIT   = 1;
    localparam int unsigned CSL_FLOW_MAN_BIT  = 2;
    localparam int unsigned CSL_MGMT_MODE_LSB = 0;
    localparam int unsigned CSL_MGMT_ROLE_BIT = 2;
    localparam int unsigned CSL_MGMT_ST_LSB   = 8;
    localparam int unsigned CSL_PA_VIRT_LSB   = 0;
    localparam int unsigned CSL_PA_P1_LSB     = 8;
    localparam int unsigned CSL_PA_P2_LSB     = 16;
    localparam int unsigned CSL_PA_W          = 5;
    localparam int unsigned CSL_CNT_W         = 8;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CSL_MGMT_UNMANAGED  = 2'h0;
    localparam logic [1:0] CSL_MGMT_EXT_SERIAL = 2'h1;
    localparam logic [1:0] CSL_MGMT_I2C        = 2'h2;
    localparam logic [1:0] CSL_MGMT_SPI        = 2'h3;
    localparam logic       CSL_ROLE_MAC        = 1'b0;
    localparam logic       CSL_ROLE_PHY        = 1'b1;
    localparam logic [4:0] CSL_VIRT_OFS        = 5'h00;
    localparam logic [4:0] CSL_P1_OFS          = 5'h01;
    localparam logic [4:0] CSL_P2_OFS          = 5'h02;
    localparam logic       CSL_MAC_MANUAL_SEL  = 1'b1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       fc_en;
        logic       manual_fc;
        logic [1:0] mgmt_mode;
        logic       mii_role;
        logic       addr_base;
    } csl_strap_t;

    typedef struct packed {
        logic       tx_fc;
        logic       rx_fc;
        logic       manual_sel;
        logic [4:0] virt_addr;
        logic [4:0] p1_addr;
        logic [4:0] p2_addr;
    } csl_cfg_t;

    typedef struct packed {
        logic     flow_valid;
        logic     addr_valid;
        csl_cfg_t cfg;
    } csl_eep_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam csl_strap_t CSL_STRAP_RST = '0;
    localparam csl_cfg_t   CSL_CFG_RST   = '0;

    function automatic logic [4:0] csl_phy_addr(input logic base, input logic [4:0] ofs);
        csl_phy_addr = ofs + {4'h0, base};
    endfunction : csl_phy_addr

endpackage : csl_pkg

//--- rtl/csl_strap_capture.sv
// Snapshot register for the raw strap levels.
// Assumes the capture pulse comes from the latch controller, one cycle long.

`timescale 1ns/1ps
`default_nettype none

module csl_strap_capture
    import csl_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // Capture request and live straps
    input  wire logic       capture,
    input  wire csl_strap_t strap_in,
    // Held snapshot
    output csl_strap_t      strap_q
);

    // Async reset loads a constant only; the pins are taken by the clocked capture.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strap_q <= CSL_STRAP_RST;
        end else if (capture) begin
            strap_q <= strap_in;
        end
    end

endmodule : csl_strap_capture

`default_nettype wire

//--- tb/csl_strap_latch_properties.sv
// Concurrent checks on the strap latch ports, bound to the top module.
// Assumes straps stay steady from a reset release until the outputs settle.
`timescale 1ns/1ps
`default_nettype none
module csl_strap_latch_properties
    import csl_pkg::*;
(
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  rstn,
    // Straps, reset pin, override and writes
    input wire logic                  ext_port_fc_enable_strap,
    input wire logic                  ext_port_manual_fc_strap,
    input wire logic [1:0]            mgmt_mode_strap,
    input wire logic                  mii_role_strap,
    input wire logic                  phy_addr_base_strap,
    input wire logic                  ext_reset_n,
    input wire logic                  eep_load_valid,
    input wire csl_eep_t              eep_load,
    input wire logic [CSL_ADDR_W-1:0] reg_addr,
    input wire logic [CSL_DATA_W-1:0] reg_wdata,
    input wire logic                  reg_wr,
    // Latched configuration
    input wire logic                  ext_tx_flowctl_enable,
    input wire logic                  ext_rx_flowctl_enable,
    input wire logic                  ext_manual_flowctl_select,
    input wire logic                  mgmt_unmanaged,
    input wire logic                  extended_mgmt_serial,
    input wire logic                  mgmt_i2c_slave,
    input wire logic                  mgmt_spi_slave,
    input wire logic                  mii_phy_role,
    input wire logic [4:0]            virt_phy_addr,
    input wire logic [4:0]            port1_phy_addr,
    input wire logic [4:0]            port2_phy_addr,
    input wire logic                  straps_valid
);
    // ------------------------------------------------------------
    // History helpers
    // ------------------------------------------------------------
    // Reset counts as activity, so the power-on capture never looks calm.
    logic [4:0] hi_h;
    logic [3:0] act_h;
    wire        rel  = ext_reset_n && !hi_h[0];
    wire        idle = ext_reset_n && !eep_load_valid && !reg_wr;
    wire        calm = &hi_h && !(|act_h);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hi_h  <= 5'h1f;
            act_h <= 4'hf;
        end else begin
            hi_h  <= {hi_h[3:0], ext_reset_n};
            act_h <= {act_h[2:0], eep_load_valid | reg_wr};
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    flow_enable_a: assert property (rel ##1 idle [*3] |=>
        ext_tx_flowctl_enable == $past(ext_port_fc_enable_strap, 3) &&
        ext_rx_flowctl_enable == $past(ext_port_fc_enable_strap, 3)) else $error("flow enables");
    manual_select_a: assert property (rel ##1 idle [*3] |=>
        ext_manual_flowctl_select == ($past(mii_role_strap, 3) ?
        $past(ext_port_manual_fc_strap, 3) : CSL_MAC_MANUAL_SEL)) else $error("manual select");
    mode_decode_a: assert property (rel ##1 idle [*3] |=>
        {mgmt_spi_slave, mgmt_i2c_slave, extended_mgmt_serial, mgmt_unmanaged} ==
        4'h1 << $past(mgmt_mode_strap, 3)) else $error("mode decode");
    role_capture_a: assert property (rel ##1 idle [*3] |=> straps_valid &&
        mii_phy_role == $past(mii_role_strap, 3)) else $error("role capture");
    addr_default_a: assert property (rel ##1 idle [*3] |=>
        virt_phy_addr == {4'h0, $past(phy_addr_base_strap, 3)} && port1_phy_addr ==
        virt_phy_addr + 5'h01 && port2_phy_addr == virt_phy_addr + 5'h02) else $error("addr");
    ext_reset_valid_a: assert property (!ext_reset_n [*4] |-> !straps_valid)
        else $error("valid during reset");
    eep_addr_a: assert property (eep_load_valid && eep_load.addr_valid && calm ##1
        idle [*3] |=> virt_phy_addr == $past(eep_load.cfg.virt_addr, 4) &&
        port2_phy_addr == $past(eep_load.cfg.p2_addr, 4)) else $error("override addr");
    host_flow_a: assert property (reg_wr && reg_addr == CSL_OFF_FLOW && calm &&
        !eep_load_valid ##1 idle [*3] |=> ext_tx_flowctl_enable == $past(reg_wdata[0], 4) &&
        ext_manual_flowctl_select == $past(reg_wdata[2], 4)) else $error("host flow");
    held_values_a: assert property (calm |-> $stable(mii_phy_role) &&
        $stable(virt_phy_addr) && $stable(ext_tx_flowctl_enable)) else $error("values moved");
endmodule : csl_strap_latch_properties

bind csl_strap_latch csl_strap_latch_properties u_props (.core_clk, .rstn,
    .ext_port_fc_enable_strap, .ext_port_manual_fc_strap, .mgmt_mode_strap, .mii_role_strap,
    .phy_addr_base_strap, .ext_reset_n, .eep_load_valid, .eep_load, .reg_addr, .reg_wdata,
    .reg_wr, .ext_tx_flowctl_enable, .ext_rx_flowctl_enable, .ext_manual_flowctl_select,
    .mgmt_unmanaged, .extended_mgmt_serial, .mgmt_i2c_slave, .mgmt_spi_slave, .mii_phy_role,
    .virt_phy_addr, .port1_phy_addr, .port2_phy_addr, .straps_valid);
`default_nettype wire

//--- tb/csl_strap_board.sv
// Board model: strap resistors and the system reset source.
// Assumes the bench picks the fitted strap set and requests reset pulses.
`timescale 1ns/1ps
`default_nettype none
module csl_strap_board
    import csl_pkg::*;
(
    // Bench requests
    input  wire csl_strap_t fit,
    input  wire logic       fitted,
    input  wire logic       pin_reset_req,
    // Board pins
    output logic            ext_port_fc_enable_strap,
    output logic            ext_port_manual_fc_strap,
    output logic [1:0]      mgmt_mode_strap,
    output logic            mii_role_strap,
    output logic            phy_addr_base_strap,
    output logic            ext_reset_n
);
    // Unfitted straps float to the internal pull-up, so every pin reads high.
    wire csl_strap_t lvl = fitted ? fit : '1;
    assign ext_port_fc_enable_strap = lvl.fc_en;
    assign ext_port_manual_fc_strap = lvl.manual_fc;
    assign mgmt_mode_strap          = lvl.mgmt_mode;
    assign mii_role_strap           = lvl.mii_role;
    assign phy_addr_base_strap      = lvl.addr_base;
    assign ext_reset_n              = !pin_reset_req;
endmodule : csl_strap_board
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the strap latch.
// Assumes the board model drives the straps and reset pin; the bench is the host.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import csl_pkg::*;
;
    logic core_clk, rstn, fitted, pin_reset_req, eep_load_valid, reg_wr, reg_rd;
    logic ext_port_fc_enable_strap, ext_port_manual_fc_strap, mii_role_strap;
    logic phy_addr_base_strap, ext_reset_n, ext_tx_flowctl_enable, ext_rx_flowctl_enable;
    logic ext_manual_flowctl_select, mgmt_unmanaged, extended_mgmt_serial, mgmt_i2c_slave;
    logic mgmt_spi_slave, mii_phy_role, straps_valid;
    logic [1:0] mgmt_mode_strap;
    logic [4:0] virt_phy_addr, port1_phy_addr, port2_phy_addr;
    logic [CSL_ADDR_W-1:0] reg_addr;
    logic [CSL_DATA_W-1:0] reg_wdata, reg_rdata;
    csl_eep_t   eep_load;
    csl_strap_t fit, cur;
    int         err_count, n_compared;

    csl_strap_board board (.fit, .fitted, .pin_reset_req, .ext_port_fc_enable_strap,
        .ext_port_manual_fc_strap, .mgmt_mode_strap, .mii_role_strap, .phy_addr_base_strap,
        .ext_reset_n);
    csl_strap_latch DUT (.core_clk, .rstn, .ext_port_fc_enable_strap, .ext_port_manual_fc_strap,
        .mgmt_mode_strap, .mii_role_strap, .phy_addr_base_strap, .ext_reset_n, .eep_load_valid,
        .eep_load, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_tx_flowctl_enable,
        .ext_rx_flowctl_enable, .ext_manual_flowctl_select, .mgmt_unmanaged,
        .extended_mgmt_serial, .mgmt_i2c_slave, .mgmt_spi_slave, .mii_phy_role,
        .virt_phy_addr, .port1_phy_addr, .port2_phy_addr, .straps_valid);

    always #12.5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task conclude;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task reg_check(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 chk(nm, reg_rdata, e);
    endtask : reg_check

    task check_cfg(input csl_strap_t s);
        logic [4:0] b;
        b = {4'h0, s.addr_base};
        chk("tx", ext_tx_flowctl_enable, s.fc_en);
        chk("rx", ext_rx_flowctl_enable, s.fc_en);
        chk("man", ext_manual_flowctl_select, s.mii_role ? s.manual_fc : 1'b1);
        chk("mode", {mgmt_spi_slave, mgmt_i2c_slave, extended_mgmt_serial, mgmt_unmanaged},
            4'h1 << s.mgmt_mode);
        chk("role", mii_phy_role, s.mii_role);
        chk("addr", {virt_phy_addr, port1_phy_addr, port2_phy_addr},
            {b, b + 5'h01, b + 5'h02});
        chk("valid", straps_valid, 1'b1);
    endtask : check_cfg

    task eep_pulse(input csl_eep_t e);
        @(posedge core_clk);
        eep_load_valid <= 1'b1;
        eep_load       <= e;
        @(posedge core_clk);
        eep_load_valid <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask : eep_pulse

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task power_on;
        repeat (3) @(posedge core_clk);
        #1 chk("rst", {mgmt_unmanaged, straps_valid, virt_phy_addr}, 32'h40);
        @(posedge core_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1 check_cfg(cur);
    endtask : power_on

    // Straps change while the pin is low, so a capture taken too early shows up.
    task ext_captures;
        csl_strap_t s;
        logic [1:0] ib;
        for (int i = 0; i < 4; i++) begin
            ib = 2'(i);
            s  = {ib[0], ^ib, ib, ib != 2'h3, ~ib[0]};
            @(posedge core_clk);
            fitted        <= 1'b1;
            fit           <= s;
            pin_reset_req <= 1'b1;
            repeat (5) @(posedge core_clk);
            #1 chk("held", {straps_valid, virt_phy_addr}, {2'b00, 3'h0, cur.addr_base});
            @(posedge core_clk);
            pin_reset_req <= 1'b0;
            repeat (6) @(posedge core_clk);
            #1 check_cfg(s);
            cur = s;
        end
    endtask : ext_captures

    task eeprom_override;
        logic [4:0] b;
        b = {4'h0, cur.addr_base};
        eep_pulse({2'b10, 3'b010, 15'h0});
        #1 chk("eflow", {ext_tx_flowctl_enable, ext_rx_flowctl_enable,
            ext_manual_flowctl_select, virt_phy_addr}, {3'b010, b});
        eep_pulse({2'b01, 3'b101, 5'h11, 5'h12, 5'h13});
        #1 chk("eaddr", {ext_tx_flowctl_enable, ext_rx_flowctl_enable, ext_manual_flowctl_select,
            virt_phy_addr, port1_phy_addr, port2_phy_addr}, {3'b010, 5'h11, 5'h12, 5'h13});
    endtask : eeprom_override

    task host_access;
        reg_write(CSL_OFF_FLOW, 32'h5);
        reg_check("flow", CSL_OFF_FLOW, 32'h5);
        repeat (2) @(posedge core_clk);
        #1 chk("hfc", {ext_tx_flowctl_enable, ext_rx_flowctl_enable,
            ext_manual_flowctl_select}, 3'b101);
        reg_write(CSL_OFF_PHYADDR, 32'h001e_0a04);
        reg_check("pa", CSL_OFF_PHYADDR, 32'h001e_0a04);
        reg_write(CSL_OFF_STATUS, 32'hffff_ffff);
        reg_check("stat", CSL_OFF_STATUS, {26'h0, cur});
        reg_check("cnt", CSL_OFF_COUNT, 32'h5);
        reg_check("mgmt", CSL_OFF_MGMT, 32'h203);
        reg_check("gap", 8'h20, 32'h0);
        chk("hpa", {virt_phy_addr, port1_phy_addr, port2_phy_addr},
            {5'h04, 5'h0a, 5'h1e});
    endtask : host_access

    initial begin
        #20000;
        err_count++;
        conclude();
    end

    initial begin
        core_clk       = 1'b0;
        rstn           = 1'b0;
        fit            = '0;
        fitted         = 1'b0;
        pin_reset_req  = 1'b0;
        eep_load_valid = 1'b0;
        eep_load       = '0;
        reg_addr       = '0;
        reg_wdata      = '0;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        err_count      = 0;
        n_compared     = 0;
        cur            = '1;
        power_on();
        ext_captures();
        eeprom_override();
        host_access();
        conclude();
    end
endmodule : testbench
`default_nettype wire
